// ==== tl_lane_pkg.sv ====
// Purpose: constants and carriers for the tunable laser lane register page
// Assumes: page byte N sits at APB byte address 4*N, low byte lane data
// Notes: multi-byte fields are big-endian, lowest page byte is the MSB
//
// Summary of operation
// [R01] page support is advertised on one constant output bit
// [R02] one bank holds exactly eight media lanes
// [R03] per-lane byte arrays start with lane 1 at the lowest byte
// [R04] bit n-1 of a one-bit-per-lane byte belongs to lane n
// [R05] grid select is bits 7-4 of the lane control byte, read-write
// [R06] bit 0 of the control byte enables fine tuning; bits 3-1 read zero
// [R07] each lane has a read-write signed 16-bit channel offset number
// [R08] each lane has a read-write signed 16-bit fine frequency offset
// [R09] each lane reports its present laser frequency, unsigned 32-bit
// [R10] each lane has a read-write signed 16-bit output power setpoint
// [R11] status bit 1 shows tuning in progress; bits 7-2 read zero
// [R12] status bit 0 shows live wavelength unlocked state
// [R13] summary bit n-1 is set while any flag of lane n is set
// [R14] host reads the summary, then the flag bytes, to serve an interrupt
// [R15] flag bit 5 latches on an out-of-range power write, clears on read
// [R16] all mask bits come up set after reset
// [R17] the page keeps no checksum
// [R18] flag bit 0 latches when tuning completes, clears on read
// [R19] flag bit 3 latches on a refused request, clears on good reprogram
// [R20] flag bit 2 latches on a channel number outside the advertised range
// [R21] masked flags still latch and summarise but raise no request
// [R22] writes to reserved or read-only bytes are ignored; reserved reads 0
package tl_lane_pkg;

    // ------------------------------------------------------------
    // page layout, byte indices
    // ------------------------------------------------------------
    localparam int LANES = 8;
    localparam logic [7:0] GRID_IDX = 8'h80;
    localparam logic [7:0] CHAN_IDX = 8'h88;
    localparam logic [7:0] FINE_IDX = 8'h98;
    localparam logic [7:0] FREQ_IDX = 8'ha8;
    localparam logic [7:0] POWER_IDX = 8'hc8;
    localparam logic [7:0] RSVD_A_IDX = 8'hd8;
    localparam logic [7:0] STATUS_IDX = 8'hde;
    localparam logic [7:0] SUMMARY_IDX = 8'he6;
    localparam logic [7:0] FLAG_IDX = 8'he7;
    localparam logic [7:0] MASK_IDX = 8'hef;
    localparam logic [7:0] RSVD_B_IDX = 8'hf7;

    // ------------------------------------------------------------
    // field positions and reset values
    // ------------------------------------------------------------
    localparam int GRID_LSB = 4;
    localparam int FINE_ON_BIT = 0;
    localparam int ACTIVE_BIT = 1;
    localparam int UNLOCK_BIT = 0;
    localparam int FLAG_W = 6;
    localparam int FL_DONE = 0;
    localparam int FL_UNLOCK = 1;
    localparam int FL_BADCH = 2;
    localparam int FL_REFUSED = 3;
    localparam int FL_FINE_OOR = 4;
    localparam int FL_POWER_OOR = 5;
    localparam logic [3:0] GRID_RST = 4'hf;
    localparam logic [5:0] MASK_RST = 6'h3f;
    localparam logic [15:0] WORD_RST = 16'h0000;

    // ------------------------------------------------------------
    // carriers to and from the laser control logic
    // ------------------------------------------------------------
    typedef struct packed {
        logic [3:0] lane_grid_select;
        logic lane_fine_adjust_on;
        logic [15:0] lane_channel_offset;
        logic [15:0] lane_fine_freq_offset;
        logic [15:0] lane_power_setpoint;
    } lane_cfg_t;

    typedef struct packed {
        logic [31:0] lane_present_freq;
        logic lane_tune_active;
        logic lane_lambda_unlocked;
        logic tune_done;
        logic tune_refused;
        logic bad_channel;
        logic fine_range_err;
    } lane_stat_t;

endpackage

// ==== tunable_laser_lane_registers.sv ====
// Purpose: APB register page for eight tunable laser media lanes
// Assumes: APB slave, zero wait states, page byte N at address 4*N
// Notes: read data is captured in the setup cycle; clear-on-read
//        clears only the flag bits that were actually returned
`timescale 1ns/1ps
module tunable_laser_lane_registers
    import tl_lane_pkg::*;
#(
    parameter int ADDR_W = 12,
    parameter logic signed [15:0] POWER_MIN = 16'sh8000,
    parameter logic signed [15:0] POWER_MAX = 16'sh7fff
)
(
    // clock and reset
    input wire logic mclk,
    input wire logic sys_rst,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // laser control side
    output lane_cfg_t [LANES-1:0] lane_cfg,
    input wire lane_stat_t [LANES-1:0] lane_stat,
    // module level
    output logic page_supported,
    output logic lane_irq_req
);

    // ------------------------------------------------------------
    // storage
    // ------------------------------------------------------------
    // host settings, one entry per lane
    logic [3:0] grid [LANES];
    logic fine_on [LANES];
    logic [15:0] chan [LANES];
    logic [15:0] fine_off [LANES];
    logic [15:0] power [LANES];

    // latched flags and their masks
    logic [FLAG_W-1:0] flags [LANES];
    logic [FLAG_W-1:0] masks [LANES];

    // summary bits and unmasked requests
    logic [LANES-1:0] lane_flag_any;
    logic [LANES-1:0] lane_pending;

    // ------------------------------------------------------------
    // address decode
    // ------------------------------------------------------------
    // page byte index and whether it is on this page
    logic [7:0] idx;
    logic mapped;

    // qualified access strobes
    logic wr_go;
    logic rd_go;
    logic rd_setup;

    // write byte in, read byte out
    logic [7:0] wbyte;
    logic [7:0] rd_byte;

    // page bytes 128..255 only, word aligned
    assign idx = paddr[9:2];
    assign mapped = (paddr[ADDR_W-1:10] == '0) && (paddr[1:0] == 2'b00)
                    && idx[7];
    assign wr_go = psel && penable && pwrite && mapped && pstrb[0];
    assign rd_go = psel && penable && !pwrite && mapped;
    assign rd_setup = psel && !penable && !pwrite;

    // only byte lane 0 carries page data
    assign wbyte = pwdata[7:0];

    // zero wait states; unmapped addresses answer with an error
    // so every access phase lasts exactly one cycle
    assign pready = 1'b1;
    assign pslverr = psel && penable && !mapped;

    // constant advertisement of this page
    assign page_supported = 1'b1; // [R01]

    // ------------------------------------------------------------
    // read multiplexer
    // ------------------------------------------------------------
    always_comb
    begin
        logic [7:0] off;
        logic [2:0] ln;

        off = 8'h00;
        ln = 3'd0;
        rd_byte = 8'h00; // [R22]
        // control bytes, one per lane
        if (idx >= GRID_IDX && idx < CHAN_IDX)
        begin
            off = idx - GRID_IDX;
            ln = off[2:0]; // [R03]
            rd_byte = {grid[ln], 3'b000, fine_on[ln]}; // [R05] [R06]
        end
        // channel offset words, high byte first
        else if (idx >= CHAN_IDX && idx < FINE_IDX)
        begin
            off = idx - CHAN_IDX;
            ln = off[3:1];
            rd_byte = off[0] ? chan[ln][7:0] : chan[ln][15:8]; // [R07]
        end
        // fine tuning offset words
        else if (idx >= FINE_IDX && idx < FREQ_IDX)
        begin
            off = idx - FINE_IDX;
            ln = off[3:1];
            rd_byte = off[0] ? fine_off[ln][7:0]
                             : fine_off[ln][15:8]; // [R08]
        end
        // present frequency, four bytes per lane
        else if (idx >= FREQ_IDX && idx < POWER_IDX)
        begin
            off = idx - FREQ_IDX;
            ln = off[4:2];
            case (off[1:0]) // [R09]
                2'd0: rd_byte = lane_stat[ln].lane_present_freq[31:24];
                2'd1: rd_byte = lane_stat[ln].lane_present_freq[23:16];
                2'd2: rd_byte = lane_stat[ln].lane_present_freq[15:8];
                default: rd_byte = lane_stat[ln].lane_present_freq[7:0];
            endcase
        end
        // power setpoint words
        else if (idx >= POWER_IDX && idx < RSVD_A_IDX)
        begin
            off = idx - POWER_IDX;
            ln = off[3:1];
            rd_byte = off[0] ? power[ln][7:0] : power[ln][15:8]; // [R10]
        end
        // live status; bytes 0xd8-0xdd fall through
        else if (idx >= STATUS_IDX && idx < SUMMARY_IDX)
        begin
            off = idx - STATUS_IDX;
            ln = off[2:0];
            rd_byte = 8'h00;
            rd_byte[ACTIVE_BIT] = lane_stat[ln].lane_tune_active; // [R11]
            rd_byte[UNLOCK_BIT] =
                lane_stat[ln].lane_lambda_unlocked; // [R12]
        end
        // one summary bit per lane
        else if (idx == SUMMARY_IDX)
        begin
            rd_byte = lane_flag_any; // [R04] [R13]
        end
        // latched flags, bits 7-6 read zero
        else if (idx >= FLAG_IDX && idx < MASK_IDX)
        begin
            off = idx - FLAG_IDX;
            ln = off[2:0];
            rd_byte = {2'b00, flags[ln]};
        end
        // masks; bytes 0xf7-0xff fall through
        else if (idx >= MASK_IDX && idx < RSVD_B_IDX)
        begin
            off = idx - MASK_IDX;
            ln = off[2:0];
            rd_byte = {2'b00, masks[ln]};
        end
        // no checksum byte anywhere on the page [R17]
    end

    // ------------------------------------------------------------
    // read data, captured in the setup cycle
    // ------------------------------------------------------------
    always_ff @(posedge mclk)
    begin
        if (sys_rst)
        begin
            prdata <= 32'h0000_0000;
        end
        else if (rd_setup)
        begin
            // an unmapped read returns zero
            prdata <= mapped ? {24'h00_0000, rd_byte} : 32'h0000_0000;
        end
    end

    // ------------------------------------------------------------
    // per-lane registers, one generate entry per lane
    // ------------------------------------------------------------
    genvar g;

    generate
        for (g = 0; g < LANES; g++)
        begin : lane
            localparam logic [7:0] LN8 = 8'(g); // [R02]

            // write strobes of this lane
            logic wr_ctl;
            logic wr_chan_hi;
            logic wr_chan_lo;
            logic wr_fine_hi;
            logic wr_fine_lo;
            logic wr_pow_hi;
            logic wr_pow_lo;
            logic wr_mask;

            // flag read and power range check
            logic rd_flag;
            logic [15:0] new_power;
            logic power_oor;

            // flag events in, read clears
            logic [FLAG_W-1:0] set;
            logic [FLAG_W-1:0] clr;

            // byte strobes for this lane, lane 1 lowest
            assign wr_ctl = wr_go && idx == GRID_IDX + LN8; // [R03]

            // word fields: the lower address holds the high byte
            assign wr_chan_hi = wr_go && idx == 8'(CHAN_IDX + 2 * LN8);
            assign wr_chan_lo = wr_go && idx == 8'(CHAN_IDX + 2 * LN8 + 1);
            assign wr_fine_hi = wr_go && idx == 8'(FINE_IDX + 2 * LN8);
            assign wr_fine_lo = wr_go && idx == 8'(FINE_IDX + 2 * LN8 + 1);
            assign wr_pow_hi = wr_go && idx == 8'(POWER_IDX + 2 * LN8);
            assign wr_pow_lo = wr_go && idx == 8'(POWER_IDX + 2 * LN8 + 1);

            // byte-per-lane mask write and flag read
            assign wr_mask = wr_go && idx == MASK_IDX + LN8;
            assign rd_flag = rd_go && idx == FLAG_IDX + LN8;

            // control byte: grid in the high nibble, fine enable bit 0
            // reserved bits 3-1 are not stored
            always_ff @(posedge mclk)
            begin
                if (sys_rst)
                begin
                    grid[g] <= GRID_RST;
                    fine_on[g] <= 1'b0;
                end
                else if (wr_ctl)
                begin
                    grid[g] <= wbyte[GRID_LSB +: 4]; // [R05]
                    fine_on[g] <= wbyte[FINE_ON_BIT]; // [R06]
                end
            end

            // channel offset number, big-endian byte pair
            always_ff @(posedge mclk)
            begin
                if (sys_rst)
                begin
                    chan[g] <= WORD_RST;
                end
                else if (wr_chan_hi)
                begin
                    chan[g][15:8] <= wbyte; // [R07]
                end
                else if (wr_chan_lo)
                begin
                    chan[g][7:0] <= wbyte; // [R07]
                end
            end

            // fine tuning frequency offset
            always_ff @(posedge mclk)
            begin
                if (sys_rst)
                begin
                    fine_off[g] <= WORD_RST;
                end
                else if (wr_fine_hi)
                begin
                    fine_off[g][15:8] <= wbyte; // [R08]
                end
                else if (wr_fine_lo)
                begin
                    fine_off[g][7:0] <= wbyte; // [R08]
                end
            end

            // power setpoint; range is judged when the low byte lands
            // a lone high byte write is never range checked
            assign new_power = {power[g][15:8], wbyte};
            assign power_oor = wr_pow_lo &&
                ($signed(new_power) < POWER_MIN ||
                 $signed(new_power) > POWER_MAX); // [R15]

            always_ff @(posedge mclk)
            begin
                if (sys_rst)
                begin
                    power[g] <= WORD_RST;
                end
                else if (wr_pow_hi)
                begin
                    power[g][15:8] <= wbyte; // [R10]
                end
                else if (wr_pow_lo)
                begin
                    power[g][7:0] <= wbyte; // [R10]
                end
            end

            // masks, all set out of reset
            always_ff @(posedge mclk)
            begin
                if (sys_rst)
                begin
                    masks[g] <= MASK_RST; // [R16]
                end
                else if (wr_mask)
                begin
                    masks[g] <= wbyte[FLAG_W-1:0];
                end
            end

            // flag events of this lane
            always_comb
            begin
                set = '0;
                set[FL_DONE] = lane_stat[g].tune_done; // [R18]
                set[FL_UNLOCK] = lane_stat[g].lane_lambda_unlocked;
                set[FL_BADCH] = lane_stat[g].bad_channel; // [R20]
                set[FL_REFUSED] = lane_stat[g].tune_refused; // [R19]
                set[FL_FINE_OOR] = lane_stat[g].fine_range_err;
                set[FL_POWER_OOR] = power_oor; // [R15]
            end

            // read clears only bits that were returned to the host
            // a tuning completion also drops the refused flag
            always_comb
            begin
                clr = rd_flag ? prdata[FLAG_W-1:0] : '0; // [R15] [R18]
                if (lane_stat[g].tune_done)
                begin
                    clr[FL_REFUSED] = 1'b1; // [R19]
                end
            end

            // latched flags; a new event wins over any clear
            // an event between setup and access survives the read
            always_ff @(posedge mclk)
            begin
                if (sys_rst)
                begin
                    flags[g] <= '0;
                end
                else
                begin
                    flags[g] <= (flags[g] & ~clr) | set;
                end
            end

            // summary and unmasked request per lane
            assign lane_flag_any[g] = |flags[g]; // [R04] [R13]
            assign lane_pending[g] = |(flags[g] & ~masks[g]); // [R21]

            // configuration handed to the laser control logic
            // settings show right after the access edge, with no extra register stage
            assign lane_cfg[g].lane_grid_select = grid[g];
            assign lane_cfg[g].lane_fine_adjust_on = fine_on[g];
            assign lane_cfg[g].lane_channel_offset = chan[g];
            assign lane_cfg[g].lane_fine_freq_offset = fine_off[g];
            assign lane_cfg[g].lane_power_setpoint = power[g];
        end
    endgenerate

    // ------------------------------------------------------------
    // module interrupt request from unmasked flags
    // masked flags still show in the summary byte
    // ------------------------------------------------------------
    assign lane_irq_req = |lane_pending; // [R21]

endmodule

// ==== tl_lane_checker.sv ====
// Purpose: port assertions for the lane register page
// Assumes: page byte N sits at byte address 4*N, zero wait states
// Notes: bound to every instance of the register page
`timescale 1ns/1ps
module tl_lane_checker
    import tl_lane_pkg::*;
#(
    parameter int ADDR_W = 12
)
(
    // clock and reset
    input wire logic mclk,
    input wire logic sys_rst,
    // apb
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // lanes and module level
    input wire lane_cfg_t [LANES-1:0] lane_cfg,
    input wire lane_stat_t [LANES-1:0] lane_stat,
    input wire logic page_supported,
    input wire logic lane_irq_req
);
    // ------------------------------------------------------------
    // qualifiers and properties
    // ------------------------------------------------------------
    default clocking @(posedge mclk); endclocking
    default disable iff (sys_rst);
    // a committed byte write, and the setup edge of a read
    wire wr_acc = psel && penable && pwrite && pstrb[0];
    wire rd_set = psel && !penable && !pwrite;
    a_page_adv: assert property (page_supported)
        else $error("page support bit low");
    a_grid_reset: assert property ($fell(sys_rst) |->
        lane_cfg[7].lane_grid_select == GRID_RST)
        else $error("grid select not at reset code");
    a_irq_reset: assert property ($fell(sys_rst) |-> !lane_irq_req)
        else $error("request raised with all masks set");
    a_grid_write: assert property (wr_acc && paddr[11:5] == 7'h10
        && paddr[1:0] == 2'b00 |=>
        lane_cfg[$past(paddr[4:2])].lane_grid_select == $past(pwdata[7:4])
        && lane_cfg[$past(paddr[4:2])].lane_fine_adjust_on
        == $past(pwdata[0]))
        else $error("control byte write lost");
    a_chan_high: assert property (wr_acc && paddr == 12'h220 |=>
        lane_cfg[0].lane_channel_offset[15:8] == $past(pwdata[7:0]))
        else $error("channel high byte write lost");
    a_status_read: assert property (rd_set && paddr == 12'h378 |=>
        prdata[7:0] == {6'h00, $past(lane_stat[0].lane_tune_active),
        $past(lane_stat[0].lane_lambda_unlocked)})
        else $error("status byte wrong");
    a_freq_read: assert property (rd_set && paddr == 12'h2a0 |=>
        prdata[7:0] == $past(lane_stat[0].lane_present_freq[31:24]))
        else $error("frequency byte wrong");
    a_unmapped_err: assert property (psel && penable
        && paddr < 12'h200 |-> pslverr)
        else $error("no error on unmapped address");
    a_ro_ignored: assert property (wr_acc && paddr >= 12'h2a0
        && paddr < 12'h320 |=> $stable(lane_cfg))
        else $error("read-only write changed settings");
    a_read_upper: assert property (psel && penable && !pwrite |->
        prdata[31:8] == 24'h000000)
        else $error("upper read data not zero");
endmodule
bind tunable_laser_lane_registers tl_lane_checker #(.ADDR_W(ADDR_W)) chk (
    .mclk(mclk), .sys_rst(sys_rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .lane_cfg(lane_cfg), .lane_stat(lane_stat),
    .page_supported(page_supported), .lane_irq_req(lane_irq_req)
);

// ==== laser_lane_model.sv ====
// Purpose: behavioural laser controller for eight lanes
// Assumes: a settings change while idle and in range starts a tuning run
// Notes: a change while busy is refused; a channel above CHAN_MAX is bad
//        and a fine offset above FINE_MAX is out of range
`timescale 1ns/1ps
module laser_lane_model
    import tl_lane_pkg::*;
#(
    parameter int TUNE_CYC = 20,
    parameter logic signed [15:0] CHAN_MAX = 16'sh0064,
    parameter logic signed [15:0] FINE_MAX = 16'sh03e8
)
(
    // clock and reset
    input wire logic mclk,
    input wire logic sys_rst,
    // settings in, status out
    input wire lane_cfg_t [LANES-1:0] lane_cfg,
    output lane_stat_t [LANES-1:0] lane_stat
);
    lane_cfg_t [LANES-1:0] last_cfg;
    int busy [LANES];
    // ------------------------------------------------------------
    // tuning runs, one countdown per lane, events are one-cycle pulses
    // ------------------------------------------------------------
    always @(posedge mclk)
    begin
        for (int n = 0; n < LANES; n++)
        begin
            last_cfg[n] <= lane_cfg[n];
            lane_stat[n].lane_present_freq <=
                {8'h2f, 8'(n), lane_cfg[n].lane_channel_offset};
            lane_stat[n].lane_tune_active <= busy[n] != 0;
            lane_stat[n].lane_lambda_unlocked <= busy[n] != 0;
            lane_stat[n].tune_refused <= 1'b0;
            lane_stat[n].bad_channel <= 1'b0;
            lane_stat[n].fine_range_err <= 1'b0;
            lane_stat[n].tune_done <= busy[n] == 1;
            if (sys_rst)
                busy[n] <= 0;
            else if (lane_cfg[n] != last_cfg[n])
            begin
                if (busy[n] != 0)
                    lane_stat[n].tune_refused <= 1'b1;
                else if ($signed(lane_cfg[n].lane_fine_freq_offset) >
                         FINE_MAX)
                    lane_stat[n].fine_range_err <= 1'b1;
                else if ($signed(lane_cfg[n].lane_channel_offset) > CHAN_MAX)
                    lane_stat[n].bad_channel <= 1'b1;
                else
                    busy[n] <= TUNE_CYC;
            end
            else if (busy[n] != 0)
                busy[n] <= busy[n] - 1;
        end
    end
endmodule

// ==== tb_tunable_laser_lane_registers.sv ====
// Purpose: self-checking bench for the lane register page
// Assumes: zero-wait apb slave, page byte N at byte address 4*N
// Notes: power range narrowed to +-1000 so a bad setpoint can be written
`timescale 1ns/1ps
`define CHK(got, exp) begin check_count++; if ((got) !== (exp)) begin \
    err_count++; \
    $display("unexpected at %0t: got %h expected %h", $time, got, exp); \
    end end
module tb_tunable_laser_lane_registers
    import tl_lane_pkg::*;
    ;
    logic mclk, sys_rst, psel, penable, pwrite, pready, pslverr, e;
    logic page_supported, lane_irq_req;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata;
    logic [3:0] pstrb;
    logic [7:0] q;
    lane_cfg_t [LANES-1:0] lane_cfg;
    lane_stat_t [LANES-1:0] lane_stat;
    int err_count = 0;
    int check_count = 0;
    // ------------------------------------------------------------
    // design, laser model and clock
    // ------------------------------------------------------------
    tunable_laser_lane_registers #(.POWER_MIN(16'shfc18),
        .POWER_MAX(16'sh03e8)) dut (.mclk(mclk), .sys_rst(sys_rst),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .lane_cfg(lane_cfg), .lane_stat(lane_stat),
        .page_supported(page_supported), .lane_irq_req(lane_irq_req));
    laser_lane_model model (.mclk(mclk), .sys_rst(sys_rst),
        .lane_cfg(lane_cfg), .lane_stat(lane_stat));
    initial
    begin
        mclk = 1'b0;
        forever #12.5 mclk = ~mclk;
    end
    // ------------------------------------------------------------
    // tasks
    // ------------------------------------------------------------
    // one apb transfer; q and e take the answer at the pready edge
    task automatic xfer(input logic w, input logic [7:0] b,
        input logic [7:0] d);
        @(posedge mclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= {2'b00, b, 2'b00};
        pwdata <= {24'h000000, d};
        @(posedge mclk);
        penable <= 1'b1;
        do
            @(posedge mclk);
        while (pready !== 1'b1);
        q = prdata[7:0];
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        #1;
    endtask
    task automatic expect_rd(input logic [7:0] b, input logic [7:0] x);
        xfer(1'b0, b, 8'h00);
        `CHK(q, x)
    endtask
    // poll a lane status byte: tuning seen to start, then to end
    task automatic wait_idle(input int n);
        int k;
        k = 0;
        do
            xfer(1'b0, 8'(222 + n), 8'h00);
        while (q[ACTIVE_BIT] !== 1'b1 && k++ < 5);
        do
            xfer(1'b0, 8'(222 + n), 8'h00);
        while (q[ACTIVE_BIT] !== 1'b0 && k++ < 60);
        `CHK(q[ACTIVE_BIT], 1'b0)
    endtask
    task automatic stop_test();
        $display("checks %0d mismatches %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    // watchdog: the tests need well under 2000 cycles
    initial
    begin
        #(25 * 20000);
        err_count++;
        stop_test();
    end
    // ------------------------------------------------------------
    // tests
    // ------------------------------------------------------------
    initial
    begin
        sys_rst = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h00000000;
        pstrb = 4'h1;
        repeat (2) @(posedge mclk);
        sys_rst <= 1'b0;
        expect_rd(8'd128, 8'hf0);
        expect_rd(8'd246, 8'h3f);
        expect_rd(8'd137, 8'h00);
        `CHK(page_supported, 1'b1)
        $display("test reset values done");
        // grid codes 0 to 7, one lane each, reserved bits written high
        for (int n = 0; n < LANES; n++)
        begin
            xfer(1'b1, 8'(128 + n), {4'(n), 3'b111, 1'(n)});
            `CHK(lane_cfg[n].lane_grid_select, 4'(n))
        end
        for (int n = 0; n < LANES; n++)
            expect_rd(8'(128 + n), {4'(n), 3'b000, 1'(n)});
        wait_idle(7);
        expect_rd(8'd230, 8'hff);
        `CHK(lane_irq_req, 1'b0)
        for (int n = 0; n < LANES; n++)
            expect_rd(8'(231 + n), 8'h03);
        expect_rd(8'd230, 8'h00);
        $display("test lane controls done");
        // retune lane 1, then change it again while it is busy
        xfer(1'b1, 8'd136, 8'h00);
        xfer(1'b1, 8'd137, 8'h05);
        xfer(1'b1, 8'd152, 8'hff);
        xfer(1'b1, 8'd153, 8'h38);
        `CHK(lane_cfg[0].lane_channel_offset, 16'h0005)
        `CHK(lane_cfg[0].lane_fine_freq_offset, 16'hff38)
        expect_rd(8'd231, 8'h0a);
        wait_idle(0);
        expect_rd(8'd231, 8'h03);
        expect_rd(8'd137, 8'h05);
        for (int k = 0; k < 4; k++)
            expect_rd(8'(168 + k), 8'(32'h2f000005 >> (24 - 8 * k)));
        // channel above the lane's range on lane 4
        xfer(1'b1, 8'd143, 8'h70);
        xfer(1'b1, 8'd158, 8'h10);
        wait_idle(3);
        expect_rd(8'd230, 8'h08);
        expect_rd(8'd234, 8'h14);
        $display("test tuning flags done");
        // unmask the power flag of lane 5, then write 1024
        xfer(1'b1, 8'd243, 8'h1f);
        `CHK(lane_irq_req, 1'b0)
        xfer(1'b1, 8'd208, 8'h04);
        xfer(1'b1, 8'd209, 8'h00);
        `CHK(lane_cfg[4].lane_power_setpoint, 16'h0400)
        xfer(1'b1, 8'd160, 8'h01);
        wait_idle(4);
        `CHK(lane_irq_req, 1'b1)
        expect_rd(8'd235, 8'h23);
        `CHK(lane_irq_req, 1'b0)
        expect_rd(8'd235, 8'h00);
        $display("test power range done");
        // unmapped, read-only, reserved and strobe-less accesses
        xfer(1'b0, 8'd1, 8'h00);
        `CHK({e, q}, 9'h100)
        xfer(1'b1, 8'd168, 8'hff);
        expect_rd(8'd168, 8'h2f);
        xfer(1'b1, 8'd216, 8'hff);
        expect_rd(8'd216, 8'h00);
        @(posedge mclk);
        pstrb <= 4'h0;
        xfer(1'b1, 8'd129, 8'hff);
        @(posedge mclk);
        pstrb <= 4'h1;
        expect_rd(8'd129, 8'h11);
        $display("test access refusals done");
        stop_test();
    end
endmodule
